// File: src/jsa_pkg.sv
package jsa_pkg;
  // Scan chain geometry
  localparam int BND_LEN     = 134;
  localparam int PORT_PINS   = 64;
  localparam int PORT_BASE   = 6;
  localparam int RST_EN_4P   = 0;
  localparam int RST_IO_4P   = 1;
  localparam int RST_EN_8P   = 2;
  localparam int RST_IO_8P   = 3;
  localparam int XTAL_BIT    = 4;
  localparam int WPU_BIT     = 5;

  // Instruction register
  localparam int          IR_LEN        = 16;
  localparam logic [15:0] IR_EXTEST     = 16'h0000;
  localparam logic [15:0] IR_SAMPLE     = 16'h0002;
  localparam logic [15:0] IR_IDCODE     = 16'h0004;
  localparam logic [15:0] IR_BYPASS     = 16'hffff;
  localparam logic [15:0] IR_FLASH_CTRL = 16'h0082;
  localparam logic [15:0] IR_FLASH_DATA = 16'h0083;
  localparam logic [15:0] IR_RESET      = 16'h0000;
  localparam logic [15:0] IR_CAPTURE    = 16'h0001;

  // Identity word layout
  localparam int ID_LEN      = 32;
  localparam int ID_VER_LSB  = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB  = 1;

  // Indirect access word layout
  localparam int         IND_LEN  = 20;
  localparam int         IND_DATA = 18;
  localparam int         OP_MSB   = 19;
  localparam int         OP_LSB   = 18;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h3;

  // Host controller register map and sequencing
  localparam logic [3:0] HOST_CTRL_ADDR = 4'h0;
  localparam logic [3:0] HOST_LEN_ADDR  = 4'h4;
  localparam logic [3:0] HOST_DATA_ADDR = 4'h8;
  localparam int         CTRL_GO        = 0;
  localparam int         CTRL_IR        = 1;
  localparam int         CTRL_RST       = 2;
  localparam int         TCK_HALF       = 8;
  localparam logic [7:0] RESET_STEPS    = 8'h05;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jsa_tap_t;
endpackage

// File: src/jsa_link_if.sv
`timescale 1ns/1ps
interface jsa_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  modport dev  (input tck, input tms, input tdi, output tdo);
  modport host (output tck, output tms, output tdi, input tdo);
endinterface

// File: src/jsa_dev.sv
// Operation
// RULE1 - Boundary chain is one 134-bit shift path
// RULE2 - EXTEST captures and updates; SAMPLE only captures
// RULE3 - Four-port part: reset cells at 0,1
// RULE4 - Eight-port part: reset cells at 2,3
// RULE5 - Bit 4 captures clock pin, no update
// RULE6 - Bit 5 carries global weak-pullup enable
// RULE7 - Pin cells: even enable, odd data
// RULE8 - EXTEST forces all core inputs high
// RULE9 - BYPASS selects one-stage bypass register
// RULE10 - IDCODE shifts fixed 32-bit identity word
// RULE11 - Host selects register, then shifts commands
// RULE12 - Command: opcode 19:18, payload 17:0
// RULE13 - Opcode 0x poll, 10 read, 11 write
// RULE14 - Poll captures status, never updates
// RULE15 - Read starts after two shifted bits
// RULE16 - Write payload is left-justified at 17
// RULE17 - Host polls busy, keeps instruction steady
// RULE18 - Status word: zero, read data, busy
// RULE19 - Busy spans operation; commands meanwhile are held
// RULE20 - Command during busy waits for idle poll
// RULE21 - Read data right-justified above busy
// RULE22 - 16-bit instruction codes for scan and ID
// RULE23 - Codes 0x0082/0x0083 select indirect windows
`timescale 1ns/1ps
module jsa_dev import jsa_pkg::*; #(
  parameter bit          EIGHT_PORT = 1'b1,
  parameter logic [3:0]  ID_VERSION = 4'h1,  // Arbitrary value
  parameter logic [15:0] ID_PART    = 16'h00a5, // Arbitrary value
  parameter logic [10:0] ID_MFR     = 11'h05a  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Test link
  jsa_link_if.dev                   link,
  // Pins
  input  wire logic [PORT_PINS-1:0] port_pin_i,
  output logic      [PORT_PINS-1:0] port_pin_o,
  output logic      [PORT_PINS-1:0] port_pin_oe_o,
  output logic                      port_wpu_o,
  input  wire logic                 rst_pin_i,
  output logic                      rst_pin_o,
  output logic                      rst_pin_oe_o,
  input  wire logic                 external_clock_input_pin_i,
  // Core side of the pins
  input  wire logic [PORT_PINS-1:0] core_port_out_i,
  input  wire logic [PORT_PINS-1:0] core_port_oe_i,
  output logic      [PORT_PINS-1:0] core_port_in_o,
  input  wire logic                 core_wpu_i,
  input  wire logic                 core_rst_en_i,
  output logic                      core_rst_in_o,
  output logic                      core_xtal_o,
  // Indirect register access
  output logic                      ind_start_o,
  output logic                      ind_write_o,
  output logic                      target_register_select_o,
  output logic      [IND_DATA-1:0]  write_payload_o,
  input  wire logic                 ind_done_i,
  input  wire logic [IND_DATA-1:0]  read_payload_i
);
  localparam int SYNC_W = PORT_PINS + 5;
  localparam int RST_EN = EIGHT_PORT ? RST_EN_8P : RST_EN_4P; // RULE3 RULE4
  localparam int RST_IO = EIGHT_PORT ? RST_IO_8P : RST_IO_4P; // RULE3 RULE4

  function automatic int oe_cell(int i);
    return PORT_BASE + 2 * i;
  endfunction

  function automatic jsa_tap_t tap_next(jsa_tap_t s, logic tms);
    unique case (s)
      TAP_RESET:    return tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     return tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   return tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   return tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: return tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: return tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: return tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: return tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   return tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   return tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   return tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: return tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: return tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: return tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: return tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   return tms ? TAP_SEL_DR   : TAP_IDLE;
    endcase
  endfunction

  logic [SYNC_W-1:0]    sync1_q, sync2_q;
  logic                 tck_prev_q, tck_s, tms_s, tdi_s, xtal_s, rstp_s, rise, fall;
  logic [PORT_PINS-1:0] port_s;
  jsa_tap_t             tap_q;
  logic [IR_LEN-1:0]    ir_sh_q, ir_q;
  logic [BND_LEN-1:0]   bnd_sh_q, bnd_upd_q, cap_vec;
  logic [ID_LEN-1:0]    id_sh_q;
  logic                 byp_q, pend_q, busy_q;
  logic [IND_LEN-1:0]   ind_sh_q, pend_sh_q, cmd;
  logic [IND_DATA-1:0]  rd_q;
  logic                 sel_bnd, sel_id, sel_ind, extest, cap_dr, shf_dr, upd_dr;
  logic                 go_pend, go_new, dr_bit0;

  // Every link and pin input crosses two flops before use
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q    <= '0;
      sync2_q    <= '0;
      tck_prev_q <= 1'b0;
    end else begin
      sync1_q    <= {port_pin_i, rst_pin_i, external_clock_input_pin_i,
                     link.tdi, link.tms, link.tck};
      sync2_q    <= sync1_q;
      tck_prev_q <= tck_s;
    end
  end

  assign {port_s, rstp_s, xtal_s, tdi_s, tms_s, tck_s} = sync2_q;
  assign rise   = tck_s & ~tck_prev_q;
  assign fall   = ~tck_s & tck_prev_q;

  // Instruction decode
  assign extest  = (ir_q == IR_EXTEST);                        // RULE22
  assign sel_bnd = extest || (ir_q == IR_SAMPLE);              // RULE22
  assign sel_id  = (ir_q == IR_IDCODE);                        // RULE22
  assign sel_ind = (ir_q == IR_FLASH_CTRL) || (ir_q == IR_FLASH_DATA); // RULE23
  assign cap_dr  = rise && (tap_q == TAP_CAP_DR);
  assign shf_dr  = rise && (tap_q == TAP_SHIFT_DR);
  assign upd_dr  = fall && (tap_q == TAP_UPD_DR);

  // Controller state and instruction register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tap_q   <= TAP_RESET;
      ir_sh_q <= '0;
      ir_q    <= IR_RESET;
    end else begin
      if (rise) begin
        tap_q <= tap_next(tap_q, tms_s);
        if (tap_q == TAP_CAP_IR) ir_sh_q <= IR_CAPTURE;
        if (tap_q == TAP_SHIFT_IR) ir_sh_q <= {tdi_s, ir_sh_q[IR_LEN-1:1]};
      end
      if (tap_q == TAP_RESET) ir_q <= IR_RESET;
      else if (fall && tap_q == TAP_UPD_IR) ir_q <= ir_sh_q;
    end
  end

  // Capture sources for every boundary cell
  always_comb begin
    cap_vec           = '0;
    cap_vec[RST_EN]   = core_rst_en_i;                         // RULE3 RULE4
    cap_vec[RST_IO]   = rstp_s;                                // RULE3 RULE4
    cap_vec[XTAL_BIT] = xtal_s;                                // RULE5
    cap_vec[WPU_BIT]  = core_wpu_i;                            // RULE6
    for (int i = 0; i < PORT_PINS; i++) begin
      cap_vec[oe_cell(i)]     = core_port_oe_i[i];             // RULE7
      cap_vec[oe_cell(i) + 1] = port_s[i];                     // RULE7
    end
  end

  // Boundary chain; update latches also take SAMPLE preload but drive only in EXTEST
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bnd_sh_q  <= '0;
      bnd_upd_q <= '0;
    end else if (sel_bnd) begin
      if (cap_dr) bnd_sh_q <= cap_vec;                             // RULE2
      if (shf_dr) bnd_sh_q <= {tdi_s, bnd_sh_q[BND_LEN-1:1]};      // RULE1
      if (upd_dr) bnd_upd_q <= bnd_sh_q;
    end
  end

  // Pin and core drive; core inputs read high while pins are under test
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_pin_o     <= '0;
      port_pin_oe_o  <= '0;
      port_wpu_o     <= 1'b0;
      rst_pin_o      <= 1'b0;
      rst_pin_oe_o   <= 1'b0;
      core_port_in_o <= '1;
      core_rst_in_o  <= 1'b1;
      core_xtal_o    <= 1'b1;
    end else begin
      for (int i = 0; i < PORT_PINS; i++) begin
        port_pin_o[i]    <= extest ? bnd_upd_q[oe_cell(i) + 1] : core_port_out_i[i]; // RULE2 RULE7
        port_pin_oe_o[i] <= extest ? bnd_upd_q[oe_cell(i)] : core_port_oe_i[i];     // RULE7
      end
      port_wpu_o     <= extest ? bnd_upd_q[WPU_BIT] : core_wpu_i;  // RULE6
      rst_pin_o      <= extest ? bnd_upd_q[RST_IO] : 1'b0;         // RULE3 RULE4
      rst_pin_oe_o   <= extest ? bnd_upd_q[RST_EN] : core_rst_en_i; // RULE3 RULE4
      core_port_in_o <= extest ? '1 : port_s;                      // RULE8
      core_rst_in_o  <= extest ? 1'b1 : rstp_s;                    // RULE8
      core_xtal_o    <= extest ? 1'b1 : xtal_s;                    // RULE5 RULE8
    end
  end

  // Identity and bypass registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      id_sh_q <= '0;
      byp_q   <= 1'b0;
    end else begin
      if (sel_id && cap_dr) id_sh_q <= {ID_VERSION, ID_PART, ID_MFR, 1'b1}; // RULE10
      if (sel_id && shf_dr) id_sh_q <= {tdi_s, id_sh_q[ID_LEN-1:1]};       // RULE10
      if (cap_dr) byp_q <= 1'b0;                                           // RULE9
      if (shf_dr) byp_q <= tdi_s;                                          // RULE9
    end
  end

  // A held command starts at the first capture that finds the engine idle
  assign go_pend = sel_ind && cap_dr && pend_q && !busy_q;                      // RULE20
  assign go_new  = sel_ind && upd_dr && ind_sh_q[OP_MSB] && !busy_q && !go_pend; // RULE13 RULE14
  assign cmd     = go_pend ? pend_sh_q : ind_sh_q;

  // Indirect word shift path
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ind_sh_q <= '0;
    end else if (sel_ind) begin
      if (cap_dr) ind_sh_q <= {1'b0, rd_q, busy_q};                  // RULE18 RULE21
      if (shf_dr) ind_sh_q <= {tdi_s, ind_sh_q[IND_LEN-1:1]};        // RULE12 RULE15 RULE16
    end
  end

  // Indirect operation engine
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q                   <= 1'b0;
      pend_q                   <= 1'b0;
      pend_sh_q                <= '0;
      rd_q                     <= '0;
      ind_start_o              <= 1'b0;
      ind_write_o              <= 1'b0;
      target_register_select_o <= 1'b0;
      write_payload_o          <= '0;
    end else begin
      ind_start_o <= 1'b0;
      if (ind_done_i && busy_q) begin
        busy_q <= 1'b0;                                              // RULE19
        if (!ind_write_o) rd_q <= read_payload_i;                    // RULE21
      end
      if (sel_ind && upd_dr && ind_sh_q[OP_MSB] && busy_q) begin
        pend_q    <= 1'b1;                                           // RULE19 RULE20
        pend_sh_q <= ind_sh_q;
      end
      if (go_pend || go_new) begin
        busy_q                   <= 1'b1;                            // RULE19
        pend_q                   <= 1'b0;
        ind_start_o              <= 1'b1;
        ind_write_o              <= (cmd[OP_MSB:OP_LSB] == OP_WRITE); // RULE13
        target_register_select_o <= (ir_q == IR_FLASH_DATA);         // RULE23
        write_payload_o          <= cmd[IND_DATA-1:0];               // RULE12 RULE16
      end
    end
  end

  // Outgoing bit of the selected register; unknown codes fall to bypass
  assign dr_bit0 = sel_bnd ? bnd_sh_q[0] :
                   sel_id  ? id_sh_q[0]  :
                   sel_ind ? ind_sh_q[0] : byp_q;                    // RULE9 RULE18

  // Data out changes on the falling link clock, as the link expects
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.tdo <= 1'b0;
    end else if (fall) begin
      link.tdo <= (tap_q == TAP_SHIFT_IR) ? ir_sh_q[0] :
                  (tap_q == TAP_SHIFT_DR) ? dr_bit0 : 1'b0;
    end
  end
endmodule

// File: src/jsa_host.sv
`timescale 1ns/1ps
module jsa_host import jsa_pkg::*; #(
  parameter int HALF = TCK_HALF
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Test link
  jsa_link_if.host         link,
  // Register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o
);
  typedef enum logic [2:0] {HS_IDLE, HS_RESET, HS_HEAD, HS_SHIFT, HS_TAIL} jsa_hs_t;

  jsa_hs_t     hs_q;
  logic [7:0]  cnt_q;
  logic [7:0]  len_q;
  logic        ir_op_q;
  logic [31:0] tx_q;
  logic [31:0] rx_q;
  logic [31:0] rx_next;
  logic [15:0] div_q;
  logic [1:0]  tdo_sync_q;
  logic        tick;
  logic        rise_t;
  logic        fall_t;
  logic        tms_val;
  logic        go;

  // Sequence step decoding; IR walk uses two select steps
  always_comb begin
    unique case (hs_q)
      HS_IDLE:  tms_val = 1'b0;
      HS_RESET: tms_val = (cnt_q != RESET_STEPS);
      HS_HEAD:  tms_val = ir_op_q ? (cnt_q < 8'h02) : (cnt_q == 8'h00);
      HS_SHIFT: tms_val = (cnt_q == len_q - 8'h01); // RULE11
      HS_TAIL:  tms_val = (cnt_q == 8'h00);
      default:  tms_val = 1'b0;
    endcase
  end

  assign tick    = (div_q == 16'(HALF - 1));
  assign rise_t  = tick && !link.tck;
  assign fall_t  = tick && link.tck;
  assign go      = wr_i && (addr_i == HOST_CTRL_ADDR) && (hs_q == HS_IDLE)
                   && (wdata_i[CTRL_GO] || wdata_i[CTRL_RST]);
  assign rx_next = {tdo_sync_q[1], rx_q[31:1]};

  // Returning data crosses two flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tdo_sync_q <= '0;
    end else begin
      tdo_sync_q <= {tdo_sync_q[0], link.tdo};
    end
  end

  // Link clock divider; the clock parks low between sequences
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q    <= '0;
      link.tck <= 1'b0;
    end else if (go || tick) begin
      div_q <= '0;
      if (tick && (hs_q != HS_IDLE || link.tck)) link.tck <= ~link.tck;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Data out changes only while the link clock is low; mode select is set high at a start, even in the high phase after a sequence
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.tms <= 1'b1;
      link.tdi <= 1'b0;
    end else if (go) begin
      link.tms <= 1'b1;
    end else if (fall_t) begin
      link.tms <= tms_val;
      link.tdi <= tx_q[0];
    end
  end

  // Sequencer and shift data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_q    <= HS_IDLE;
      cnt_q   <= '0;
      len_q   <= 8'h10;
      ir_op_q <= 1'b0;
      tx_q    <= '0;
      rx_q    <= '0;
    end else if (hs_q == HS_IDLE) begin
      if (wr_i && addr_i == HOST_LEN_ADDR) len_q <= wdata_i[7:0];
      if (wr_i && addr_i == HOST_DATA_ADDR) tx_q <= wdata_i;
      if (go) begin
        hs_q    <= wdata_i[CTRL_RST] ? HS_RESET : HS_HEAD;
        ir_op_q <= wdata_i[CTRL_IR];
        cnt_q   <= '0;
      end
    end else if (rise_t) begin
      cnt_q <= cnt_q + 8'h01;
      unique case (hs_q)
        HS_RESET: if (cnt_q == RESET_STEPS) hs_q <= HS_IDLE;
        HS_HEAD: begin
          if (cnt_q == (ir_op_q ? 8'h03 : 8'h02)) begin
            hs_q  <= HS_SHIFT;
            cnt_q <= '0;
          end
        end
        HS_SHIFT: begin
          tx_q <= {1'b0, tx_q[31:1]};
          rx_q <= rx_next;
          if (cnt_q == len_q - 8'h01) begin
            hs_q  <= HS_TAIL;
            cnt_q <= '0;
            if (len_q != 8'h00 && len_q < 8'h20) begin
              rx_q <= rx_next >> (6'h20 - len_q[5:0]);
            end
          end
        end
        HS_TAIL: if (cnt_q == 8'h01) hs_q <= HS_IDLE;
        default: hs_q <= HS_IDLE;
      endcase
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        HOST_CTRL_ADDR: rdata_o <= {31'h0, hs_q != HS_IDLE};
        HOST_LEN_ADDR:  rdata_o <= {24'h0, len_q};
        HOST_DATA_ADDR: rdata_o <= rx_q;
        default:        rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule

// File: bench/jsa_link_props.sv
`timescale 1ns/1ps
module jsa_link_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Host divider gives exact high phases, a low phase never shorter
  property p_tck_high; $rose(tck) |-> tck [*8] ##1 !tck; endproperty
  property p_tck_low; $fell(tck) |-> (!tck) [*8]; endproperty
  // Mode and data move only in the low phase so the device sees them settled
  property p_tms_quiet; $changed(tms) |-> !tck; endproperty
  property p_tdi_quiet; $changed(tdi) |-> !tck; endproperty
  property p_setup; $rose(tck) |-> $stable(tms) && $stable(tdi); endproperty
  // Device answer follows a fall, a few cycles late, never in the high phase
  property p_tdo_quiet; $changed(tdo) |-> !tck && !$past(tck); endproperty
  // Idle levels right after reset
  property p_host_rst; $fell(rst_i) |-> !tck && tms && !tdi; endproperty
  property p_tdo_rst; $fell(rst_i) |-> !tdo; endproperty

  a_tck_high: assert property (p_tck_high) else $error("tck high phase wrong");
  a_tck_low: assert property (p_tck_low) else $error("tck low phase short");
  a_tms_quiet: assert property (p_tms_quiet) else $error("tms moved while high");
  a_tdi_quiet: assert property (p_tdi_quiet) else $error("tdi moved while high");
  a_setup: assert property (p_setup) else $error("tms or tdi moved at rise");
  a_tdo_quiet: assert property (p_tdo_quiet) else $error("tdo moved near rise");
  a_host_rst: assert property (p_host_rst) else $error("host idle levels wrong");
  a_tdo_rst: assert property (p_tdo_rst) else $error("tdo not low after reset");

  c_rise: cover property ($rose(tck));
  c_tdo: cover property ($rose(tdo));
  c_mode: cover property (tck && tms);
endmodule

// File: bench/test_jtag_scan_and_indirect_access.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module test_jtag_scan_and_indirect_access;
  import jsa_pkg::*;
  localparam logic [3:0]  IDV  = 4'h6;     // Arbitrary value
  localparam logic [15:0] IDP  = 16'h3c5a; // Arbitrary value
  localparam logic [10:0] IDM  = 11'h2b7;  // Arbitrary value
  localparam logic [31:0] DPAT = 32'h5ac3_96e7;
  localparam logic [17:0] WPAY = 18'h2a5c0;
  localparam logic [17:0] RPAY = 18'h2d3c9;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata, q, e;
  logic [63:0] pin_in = 64'h9c3a_5e71_0f2d_b486;
  logic [63:0] c_oe = 64'h36c9_a15e_7b20_d4f3;
  logic [63:0] c_out = 64'h71e4_0c9b_a256_3fd8;
  logic [63:0] pin_o, pin_oe, c_in, eo, ev;
  logic        wpu_c = 1'b1;
  logic        rst_en_c = 1'b1;
  logic        rst_pin = 1'b0;
  logic        xtal = 1'b1;
  logic        done = 1'b0;
  logic        wpu_o, rpin_o, rpin_oe, c_rst_in, c_xtal, start, wr_op, sel;
  logic [17:0] pay;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          n_start = 0;
  int          wait_cnt = 0;
  int          k, j;

  // 200 MHz system clock
  always #2.5 clk_i = ~clk_i;

  jsa_link_if link_if ();
  jsa_dev #(.EIGHT_PORT(1'b1), .ID_VERSION(IDV), .ID_PART(IDP), .ID_MFR(IDM)) i_jsa_dev (
    .clk_i(clk_i), .rst_i(rst_i), .link(link_if), .port_pin_i(pin_in), .port_pin_o(pin_o),
    .port_pin_oe_o(pin_oe), .port_wpu_o(wpu_o), .rst_pin_i(rst_pin), .rst_pin_o(rpin_o),
    .rst_pin_oe_o(rpin_oe), .external_clock_input_pin_i(xtal), .core_port_out_i(c_out),
    .core_port_oe_i(c_oe), .core_port_in_o(c_in), .core_wpu_i(wpu_c),
    .core_rst_en_i(rst_en_c), .core_rst_in_o(c_rst_in), .core_xtal_o(c_xtal),
    .ind_start_o(start), .ind_write_o(wr_op), .target_register_select_o(sel),
    .write_payload_o(pay), .ind_done_i(done), .read_payload_i(RPAY));
  jsa_host i_jsa_host (.clk_i(clk_i), .rst_i(rst_i), .link(link_if), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  jsa_link_props i_jsa_link_props (.clk_i(clk_i), .rst_i(rst_i), .tck(link_if.tck),
    .tms(link_if.tms), .tdi(link_if.tdi), .tdo(link_if.tdo));

  // Flash side stand-in: slow on purpose so busy is seen high by a poll
  always @(posedge clk_i) begin
    done <= 1'b0;
    if (start) begin
      n_start++;
      wait_cnt = 300;
    end else if (wait_cnt > 0) begin
      wait_cnt--;
      if (wait_cnt == 0) done <= 1'b1;
    end
  end

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  // Read data is valid only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic hang();
    n_mismatch++;
    $display("MISMATCH t=%0t wait ran out", $time);
    close_out();
  endtask

  task automatic scan(input logic ins, input logic [7:0] n, input logic [31:0] d,
                      output logic [31:0] r);
    logic [31:0] c;
    c = 32'h0;
    c[CTRL_GO] = 1'b1;
    c[CTRL_IR] = ins;
    reg_wr(HOST_LEN_ADDR, {24'h0, n});
    reg_wr(HOST_DATA_ADDR, d);
    reg_wr(HOST_CTRL_ADDR, c);
    host_wait(r);
    reg_rd(HOST_DATA_ADDR, r);
  endtask

  // Busy poll on the host; a wait that runs out ends the run
  task automatic host_wait(output logic [31:0] r);
    int i;
    r = 32'h0000_0001;
    for (i = 0; i < 4000 && r[CTRL_GO] !== 1'b0; i++) reg_rd(HOST_CTRL_ADDR, r);
    if (r[CTRL_GO] !== 1'b0) hang();
  endtask

  // Walk the device to idle; the trailing read keeps the next start off the high phase
  task automatic tap_reset();
    logic [31:0] r;
    reg_wr(HOST_CTRL_ADDR, 32'h0000_0001 << CTRL_RST);
    host_wait(r);
    reg_rd(HOST_DATA_ADDR, r);
  endtask

  task automatic instr_load(input logic [15:0] v);
    logic [31:0] r;
    scan(1'b1, 8'd16, {16'h0, v}, r);
  endtask

  task automatic ind_wait();
    int i;
    for (i = 0; i < 2000 && (wait_cnt > 0 || done); i++) @(posedge clk_i);
    if (wait_cnt > 0) hang();
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Out of reset the part is in EXTEST: core inputs high, pins released
    @(posedge clk_i);
    #1;
    `CHK(c_in, {64{1'b1}})
    `CHK(pin_oe, 64'h0)
    tap_reset();
    $display("test reset done");
    instr_load(IR_IDCODE);
    scan(1'b0, 8'd32, 32'h0, q);
    `CHK(q, {IDV, IDP, IDM, 1'b1})
    instr_load(IR_BYPASS);
    scan(1'b0, 8'd8, 32'ha5, q);
    `CHK(q, 32'h4a)
    $display("test identity and bypass done");
    // Low cells under SAMPLE, second pass with every level flipped
    instr_load(IR_SAMPLE);
    for (k = 0; k < 2; k++) begin
      scan(1'b0, 8'd8, 32'h0, q);
      `CHK(q[7:2], {pin_in[0], c_oe[0], wpu_c, xtal, rst_pin, rst_en_c})
      `CHK({pin_oe, pin_o, c_in}, {c_oe, c_out, pin_in})
      @(posedge clk_i);
      pin_in <= ~pin_in;
      c_oe <= ~c_oe;
      c_out <= ~c_out;
      wpu_c <= ~wpu_c;
      xtal <= ~xtal;
      rst_pin <= ~rst_pin;
      rst_en_c <= ~rst_en_c;
    end
    // Full chain: the last 32 cells out belong to the top two ports
    scan(1'b0, 8'd134, 32'h0, q);
    for (j = 0; j < 16; j++) begin
      e[2*j] = c_oe[48+j];
      e[2*j+1] = pin_in[48+j];
    end
    `CHK(q, e)
    $display("test sample done");
    // EXTEST drives pins from the update cells
    instr_load(IR_EXTEST);
    scan(1'b0, 8'd134, DPAT, q);
    `CHK(q, e)
    eo = 64'h0;
    ev = 64'h0;
    for (j = 0; j < 13; j++) begin
      eo[j] = DPAT[6+2*j];
      ev[j] = DPAT[7+2*j];
    end
    `CHK({pin_oe, pin_o}, {eo, ev})
    `CHK({rpin_oe, rpin_o, wpu_o}, {DPAT[2], DPAT[3], DPAT[5]})
    `CHK({c_in, c_rst_in, c_xtal}, {66{1'b1}})
    $display("test extest done");
    // Indirect write, then a read shifted in while still busy
    instr_load(IR_FLASH_CTRL);
    scan(1'b0, 8'd20, {12'h0, OP_WRITE, WPAY}, q);
    `CHK({wr_op, sel, pay}, {1'b1, 1'b0, WPAY})
    scan(1'b0, 8'd1, 32'h0, q);
    `CHK(q, 32'h1)
    scan(1'b0, 8'd2, 32'h2, q);
    `CHK(n_start, 1)
    ind_wait();
    scan(1'b0, 8'd1, 32'h0, q);
    `CHK(q, 32'h0)
    `CHK(n_start, 2)
    `CHK(wr_op, 1'b0)
    ind_wait();
    scan(1'b0, 8'd19, 32'h0002_0000, q);
    `CHK(q, {13'h0, RPAY, 1'b0})
    `CHK(n_start, 2)
    instr_load(IR_FLASH_DATA);
    scan(1'b0, 8'd2, 32'h2, q);
    `CHK(n_start, 3)
    `CHK({wr_op, sel}, 2'b01)
    ind_wait();
    $display("test indirect done");
    close_out();
  end
endmodule
